/* src/toc_edge_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface toc_edge_if;
   logic rise;
   logic fall;
   logic level;
   modport src (output rise, output fall, output level);
   modport dst (input rise, input fall, input level);
endinterface : toc_edge_if
`default_nettype wire

/* src/toc_edge_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module toc_edge_sync (
   input wire logic clk, // system clock
   input wire logic rst, // sync reset, high
   input wire logic pin, // raw timer input
   toc_edge_if.src eo // filtered level and edge pulses
);
   logic s1_ff, s2_ff, s3_ff, lvl_ff, rise_ff, fall_ff;
   wire agree = (s2_ff == s3_ff);
   // -----------------------------------------
   // sample chain; s1 feeds only s2
   // -----------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         s1_ff <= 1'b0;
         s2_ff <= 1'b0;
         s3_ff <= 1'b0;
         lvl_ff <= 1'b0;
         rise_ff <= 1'b0;
         fall_ff <= 1'b0;
      end else begin
         s1_ff <= pin;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         lvl_ff <= agree ? s3_ff : lvl_ff;
         rise_ff <= agree & s3_ff & ~lvl_ff;
         fall_ff <= agree & ~s3_ff & lvl_ff;
      end
   end
   assign eo.rise = rise_ff;
   assign eo.fall = fall_ff;
   assign eo.level = lvl_ff;
endmodule : toc_edge_sync
`default_nettype wire

/* src/toc_pkg.sv */
`default_nettype none
package toc_pkg;
   localparam logic [31:0] CTRL_OFS = 32'h0000_0000;
   localparam logic [31:0] COUNT_OFS = 32'h0000_0004;
   localparam logic [31:0] RELOAD_OFS = 32'h0000_0008;
   localparam logic [31:0] STATUS_OFS = 32'h0000_000C;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_MODE_BIT = 1;
   localparam int CTRL_POL_BIT = 2;
   localparam int CTRL_PSEL_LSB = 3;
   localparam int CTRL_OE_BIT = 6;
   localparam int STAT_LEVEL_BIT = 0;
   localparam int STAT_RUN_BIT = 1;
   localparam logic [15:0] COUNT_RST = 16'h0001;
   localparam logic [15:0] RELOAD_RST = 16'h0000;
   localparam logic [15:0] COUNT_RESTART = 16'h0001;
   localparam logic [2:0] PSEL_RST = 3'h0;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   typedef enum logic {TOC_ONESHOT = 1'b0, TOC_COUNTER = 1'b1} toc_mode_t;
   typedef enum logic [1:0] {
      TOC_SEL_NONE = 2'h0, TOC_SEL_CTRL = 2'h1, TOC_SEL_COUNT = 2'h3, TOC_SEL_RELOAD = 2'h2
   } toc_sel_t;
   typedef enum logic {TOC_SEL_STATUS_N = 1'b0, TOC_SEL_STATUS = 1'b1} toc_stat_t;
endpackage : toc_pkg
`default_nettype wire

/* src/toc_timer.sv */
// Register access over AHB-Lite and the register offsets were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module toc_timer #(
   parameter int CNT_W = 16, // counter width
   parameter int PRE_W = 7 // prescaler width, divide up to 128
) (
   input wire logic SYS_CLK, // system clock, 125 MHz
   input wire logic RST, // synchronous reset, high
   input wire logic HSEL, // slave select
   input wire logic [31:0] HADDR, // byte address
   input wire logic [1:0] HTRANS, // transfer type
   input wire logic HWRITE, // write when high
   input wire logic [2:0] HSIZE, // transfer size
   input wire logic [31:0] HWDATA, // write data
   input wire logic HREADY, // bus ready in
   output logic [31:0] HRDATA, // read data
   output logic HREADYOUT, // slave ready
   output logic HRESP, // always OKAY
   input wire logic TIN, // timer input pin
   output logic TOUT, // timer output pin
   output logic IRQ // one-clock interrupt pulse
);
   // -----------------------------------------
   // address decode
   // -----------------------------------------
   function automatic toc_pkg::toc_sel_t dec_sel(input logic [31:0] a);
      toc_pkg::toc_sel_t s;
      s = toc_pkg::TOC_SEL_NONE;
      if (a == toc_pkg::CTRL_OFS) s = toc_pkg::TOC_SEL_CTRL;
      if (a == toc_pkg::COUNT_OFS) s = toc_pkg::TOC_SEL_COUNT;
      if (a == toc_pkg::RELOAD_OFS) s = toc_pkg::TOC_SEL_RELOAD;
      return s;
   endfunction : dec_sel

   logic en_ff, pol_ff, oe_ff, irq_ff, tog_ff, tout_ff;
   toc_pkg::toc_mode_t mode_ff;
   logic [2:0] psel_ff;
   logic [CNT_W-1:0] cnt_ff, rld_ff;
   logic [PRE_W-1:0] presc_ff;
   logic [31:0] hrdata_ff;
   logic ap_wr_ff;
   toc_pkg::toc_sel_t ap_sel_ff;

   toc_edge_if edge_bus ();
   toc_edge_sync u_sync (
      .clk(SYS_CLK),
      .rst(RST),
      .pin(TIN),
      .eo(edge_bus.src)
   );

   // -----------------------------------------
   // bus slave: zero wait, always OKAY
   // -----------------------------------------
   wire ap_take = HSEL & HTRANS[1] & HREADY;
   wire ap_write = ap_take & HWRITE & (HSIZE == toc_pkg::HSIZE_WORD);
   wire toc_pkg::toc_sel_t ap_sel = dec_sel(HADDR);
   wire ap_stat = (HADDR == toc_pkg::STATUS_OFS);
   wire wr_ctrl = ap_wr_ff & (ap_sel_ff == toc_pkg::TOC_SEL_CTRL);
   wire wr_cnt = ap_wr_ff & (ap_sel_ff == toc_pkg::TOC_SEL_COUNT);
   wire wr_rld = ap_wr_ff & (ap_sel_ff == toc_pkg::TOC_SEL_RELOAD);

   // -----------------------------------------
   // count events
   // -----------------------------------------
   wire oneshot = (mode_ff == toc_pkg::TOC_ONESHOT);
   wire counter = (mode_ff == toc_pkg::TOC_COUNTER);
   // divisor is 2**psel, from 1 up to 128
   wire [PRE_W:0] div_one = (PRE_W+1)'(1);
   wire [PRE_W-1:0] pre_lim = PRE_W'((div_one << psel_ff) - div_one);
   wire tick = en_ff & oneshot & (presc_ff == pre_lim);
   wire in_edge = pol_ff ? edge_bus.fall : edge_bus.rise;
   wire cnt_ev = en_ff & counter & in_edge;
   wire ev = tick | cnt_ev;
   // reload 0000H is met only after the wrap, hence the longest time-out
   wire hit = ev & (cnt_ff == rld_ff);

   // -----------------------------------------
   // next values
   // -----------------------------------------
   wire [CNT_W-1:0] cnt_inc = CNT_W'(cnt_ff + CNT_W'(1));
   wire [CNT_W-1:0] nxt_cnt = wr_cnt ? HWDATA[CNT_W-1:0] :
      hit ? toc_pkg::COUNT_RESTART :
      ev ? cnt_inc : cnt_ff;
   // a software write wins over the hardware self-disable in the same cycle
   wire nxt_en = wr_ctrl ? HWDATA[toc_pkg::CTRL_EN_BIT] :
      (hit & oneshot) ? 1'b0 : en_ff;
   wire [PRE_W-1:0] nxt_presc = (!en_ff || counter || tick) ? '0 :
      PRE_W'(presc_ff + PRE_W'(1));
   // while idle the toggle follows polarity, so enabling starts there
   wire nxt_tog = !en_ff ? pol_ff : (hit & counter) ? ~tog_ff : tog_ff;
   // one-shot holds its start level while running, so a later polarity write shows at time-out
   wire os_level = hit ? ~tog_ff : nxt_tog;
   wire nxt_level = counter ? nxt_tog : os_level;
   wire nxt_tout = oe_ff & nxt_level;
   wire cur_level = tog_ff;
   wire [31:0] stat_word = {30'h0000_0000, en_ff, cur_level};

   function automatic logic [31:0] rd_word(input toc_pkg::toc_sel_t s, input logic st,
                                            input logic [31:0] ctl, input logic [31:0] cv,
                                            input logic [31:0] rv, input logic [31:0] sv);
      logic [31:0] d;
      d = 32'h0000_0000;
      case (s)
         toc_pkg::TOC_SEL_CTRL: d = ctl;
         toc_pkg::TOC_SEL_COUNT: d = cv;
         toc_pkg::TOC_SEL_RELOAD: d = rv;
         default: d = st ? sv : 32'h0000_0000;
      endcase
      return d;
   endfunction : rd_word

   wire [31:0] ctrl_word = {25'h000_0000, oe_ff, psel_ff, pol_ff, mode_ff, en_ff};
   wire [31:0] nxt_rdata = (ap_take & ~HWRITE) ?
      rd_word(ap_sel, ap_stat, ctrl_word, 32'(cnt_ff), 32'(rld_ff), stat_word) : hrdata_ff;

   // -----------------------------------------
   // bus registers
   // -----------------------------------------
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         ap_wr_ff <= 1'b0;
         ap_sel_ff <= toc_pkg::TOC_SEL_NONE;
         hrdata_ff <= 32'h0000_0000;
      end else begin
         ap_wr_ff <= ap_write;
         ap_sel_ff <= ap_sel;
         hrdata_ff <= nxt_rdata;
      end
   end

   // -----------------------------------------
   // control register
   // -----------------------------------------
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         mode_ff <= toc_pkg::TOC_ONESHOT;
         pol_ff <= 1'b0;
         psel_ff <= toc_pkg::PSEL_RST;
         oe_ff <= 1'b0;
      end else if (wr_ctrl) begin
         mode_ff <= toc_pkg::toc_mode_t'(HWDATA[toc_pkg::CTRL_MODE_BIT]);
         pol_ff <= HWDATA[toc_pkg::CTRL_POL_BIT];
         psel_ff <= HWDATA[toc_pkg::CTRL_PSEL_LSB +: 3];
         oe_ff <= HWDATA[toc_pkg::CTRL_OE_BIT];
      end
   end

   // -----------------------------------------
   // timer core
   // -----------------------------------------
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         en_ff <= 1'b0;
         cnt_ff <= toc_pkg::COUNT_RST;
         rld_ff <= toc_pkg::RELOAD_RST;
         presc_ff <= '0;
         irq_ff <= 1'b0;
         tog_ff <= 1'b0;
         tout_ff <= 1'b0;
      end else begin
         en_ff <= nxt_en;
         cnt_ff <= nxt_cnt;
         rld_ff <= wr_rld ? HWDATA[CNT_W-1:0] : rld_ff;
         presc_ff <= nxt_presc;
         irq_ff <= hit;
         tog_ff <= nxt_tog;
         tout_ff <= nxt_tout;
      end
   end

   assign HRDATA = hrdata_ff;
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;
   assign TOUT = tout_ff;
   assign IRQ = irq_ff;

   // -----------------------------------------
   // checks
   // -----------------------------------------
   property p_os_reload;
      @(posedge SYS_CLK) disable iff (RST)
      (hit && oneshot && !ap_wr_ff) |=> (cnt_ff == 16'h0001) && !en_ff && IRQ;
   endproperty
   a_os_reload: assert property (p_os_reload)
      else $error("one-shot reload did not restart, stop and interrupt");

   property p_irq_single;
      @(posedge SYS_CLK) disable iff (RST)
      IRQ |=> !IRQ;
   endproperty
   a_irq_single: assert property (p_irq_single)
      else $error("interrupt pulse longer than one clock");

   property p_os_pulse;
      @(posedge SYS_CLK) disable iff (RST)
      (hit && oneshot && oe_ff && !ap_wr_ff) |=> (TOUT != $past(TOUT)) ##1 (TOUT == pol_ff);
   endproperty
   a_os_pulse: assert property (p_os_pulse)
      else $error("one-shot output did not invert for one clock");

   property p_ct_reload;
      @(posedge SYS_CLK) disable iff (RST)
      (hit && counter && !ap_wr_ff) |=> (cnt_ff == 16'h0001) && en_ff && IRQ;
   endproperty
   a_ct_reload: assert property (p_ct_reload)
      else $error("counter reload did not restart and keep running");

   property p_ct_toggle;
      @(posedge SYS_CLK) disable iff (RST)
      (hit && counter && oe_ff && !ap_wr_ff) |=> (TOUT != $past(TOUT)) ##1 $stable(TOUT);
   endproperty
   a_ct_toggle: assert property (p_ct_toggle)
      else $error("counter output did not toggle at reload");

   property p_step_one;
      @(posedge SYS_CLK) disable iff (RST)
      (ev && !hit && !wr_cnt) |=> (cnt_ff == 16'($past(cnt_ff) + 16'h0001));
   endproperty
   a_step_one: assert property (p_step_one)
      else $error("count did not advance by exactly one");

   property p_hold_idle;
      @(posedge SYS_CLK) disable iff (RST)
      (!en_ff && !wr_cnt) |=> $stable(cnt_ff);
   endproperty
   a_hold_idle: assert property (p_hold_idle)
      else $error("count moved while disabled");

   property p_pre_range;
      @(posedge SYS_CLK) disable iff (RST)
      (en_ff && oneshot && !ap_wr_ff) |-> (presc_ff <= pre_lim);
   endproperty
   a_pre_range: assert property (p_pre_range)
      else $error("prescaler ran past its divisor");

   property p_ct_edge;
      @(posedge SYS_CLK) disable iff (RST)
      (en_ff && counter && !ap_wr_ff && !in_edge) |=> $stable(cnt_ff);
   endproperty
   a_ct_edge: assert property (p_ct_edge)
      else $error("counter moved without a selected input edge");

   property p_init_level;
      @(posedge SYS_CLK) disable iff (RST)
      (!en_ff && counter && !ap_wr_ff) |=> (tog_ff == pol_ff);
   endproperty
   a_init_level: assert property (p_init_level)
      else $error("counter output level not set by polarity");

   property p_irq_cause;
      @(posedge SYS_CLK) disable iff (RST)
      !hit |=> !IRQ;
   endproperty
   a_irq_cause: assert property (p_irq_cause)
      else $error("interrupt raised without a reload");

   property p_cnt_write;
      @(posedge SYS_CLK) disable iff (RST)
      wr_cnt |=> (cnt_ff == 16'($past(HWDATA)));
   endproperty
   a_cnt_write: assert property (p_cnt_write)
      else $error("count write did not take effect at once");

   property p_rld_write;
      @(posedge SYS_CLK) disable iff (RST)
      wr_rld |=> (rld_ff == 16'($past(HWDATA)));
   endproperty
   a_rld_write: assert property (p_rld_write)
      else $error("reload write did not take effect at once");

   property p_os_tick;
      @(posedge SYS_CLK) disable iff (RST)
      (en_ff && oneshot && !tick && !ap_wr_ff) |=> $stable(cnt_ff);
   endproperty
   a_os_tick: assert property (p_os_tick)
      else $error("one-shot count moved without a prescaled tick");

   property p_ct_nopre;
      @(posedge SYS_CLK) disable iff (RST)
      counter |=> (presc_ff == '0);
   endproperty
   a_ct_nopre: assert property (p_ct_nopre)
      else $error("prescaler ran in counter mode");

   property p_wrap;
      @(posedge SYS_CLK) disable iff (RST)
      (ev && !hit && !wr_cnt && (cnt_ff == 16'hFFFF)) |=> (cnt_ff == 16'h0000);
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("count did not wrap to zero");

   property p_edge_lvl;
      @(posedge SYS_CLK) disable iff (RST)
      (edge_bus.rise || edge_bus.fall) |-> (edge_bus.level == edge_bus.rise);
   endproperty
   a_edge_lvl: assert property (p_edge_lvl)
      else $error("input edge disagrees with filtered level");

   property p_ct_keep;
      @(posedge SYS_CLK) disable iff (RST)
      (en_ff && counter && !ap_wr_ff) |=> en_ff;
   endproperty
   a_ct_keep: assert property (p_ct_keep)
      else $error("counter mode disabled itself");

endmodule : toc_timer
`default_nettype wire

/* verif/toc_timer_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module toc_timer_tb;
   logic sys_clk, rst, hsel, hwrite, hreadyout, hresp, tout, irq, irq_prev, tin, src_req, src_busy;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata;
   logic [7:0] src_n;
   int err_total = 0;
   int cmp_count = 0;
   int c0, c3, i;
   toc_timer dut (.SYS_CLK(sys_clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
      .HREADYOUT(hreadyout), .HRESP(hresp), .TIN(tin), .TOUT(tout), .IRQ(irq));
   toc_tin_src src (.clk(sys_clk), .rst(rst), .req(src_req), .n_edges(src_n), .pin_ff(tin),
      .busy(src_busy));
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   // -------------------------------------------------------------
   // common tasks
   // -------------------------------------------------------------
   task check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : final_report
   task tmo;
      err_total++;
      $display("MISMATCH at %0t: wait timed out", $time);
      final_report();
   endtask : tmo
   task wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
         if (n > 100) tmo();
      end while (hreadyout !== 1'b1);
   endtask : wait_rdy
   // the master never assumes zero wait states even though this slave has them
   task bus(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [2:0] sz,
      output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      hsize <= sz;
      wait_rdy();
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy();
      r = hrdata;
   endtask : bus
   task wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, toc_pkg::HSIZE_WORD, r);
   endtask : wr
   task rd(input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] r;
      bus(1'b0, a, 32'h0000_0000, toc_pkg::HSIZE_WORD, r);
      check(r, exp);
   endtask : rd
   task wait_irq(output int cyc);
      cyc = 0;
      do begin
         @(posedge sys_clk);
         cyc++;
         if (cyc > 3000) tmo();
      end while (irq !== 1'b1);
   endtask : wait_irq
   // send n transitions on the input pin, count interrupt pulses until the pipe has settled
   task edges(input logic [7:0] n, output int irqs);
      int k;
      irqs = 0;
      k = 0;
      src_n <= n;
      src_req <= 1'b1;
      @(posedge sys_clk);
      src_req <= 1'b0;
      do begin
         @(posedge sys_clk);
         k++;
         if (k > 3000) tmo();
         if (irq === 1'b1) irqs++;
      end while (src_busy === 1'b1 || k < 12);
      repeat (12) begin
         @(posedge sys_clk);
         if (irq === 1'b1) irqs++;
      end
   endtask : edges
   // -------------------------------------------------------------
   // scenarios
   // -------------------------------------------------------------
   task t_reset;
      rd(toc_pkg::CTRL_OFS, 32'h0000_0000);
      rd(toc_pkg::COUNT_OFS, 32'h0000_0001);
      rd(toc_pkg::RELOAD_OFS, 32'h0000_0000);
      rd(toc_pkg::STATUS_OFS, 32'h0000_0000);
      rd(32'h0000_0010, 32'h0000_0000);
      check({31'h0, tout}, 32'h0000_0000);
      check({31'h0, hresp}, 32'h0000_0000);
   endtask : t_reset
   task t_oneshot(input logic [2:0] sel, output int cyc);
      wr(toc_pkg::CTRL_OFS, 32'h0000_0040 | {26'h0, sel, 3'h0});
      wr(toc_pkg::COUNT_OFS, 32'h0000_0001);
      wr(toc_pkg::RELOAD_OFS, 32'h0000_0004);
      check({31'h0, tout}, 32'h0000_0000);
      wr(toc_pkg::CTRL_OFS, 32'h0000_0041 | {26'h0, sel, 3'h0});
      wait_irq(cyc);
      check({31'h0, tout}, 32'h0000_0001);
      @(posedge sys_clk);
      check({31'h0, tout}, 32'h0000_0000);
      rd(toc_pkg::COUNT_OFS, 32'h0000_0001);
      rd(toc_pkg::CTRL_OFS, 32'h0000_0040 | {26'h0, sel, 3'h0});
      repeat (20) @(posedge sys_clk);
      rd(toc_pkg::COUNT_OFS, 32'h0000_0001);
   endtask : t_oneshot
   // polarity flipped after start: output stays put, then changes for good at time-out
   task t_lasting;
      int c;
      wr(toc_pkg::CTRL_OFS, 32'h0000_0040);
      wr(toc_pkg::COUNT_OFS, 32'h0000_0001);
      wr(toc_pkg::RELOAD_OFS, 32'h0000_0020);
      wr(toc_pkg::CTRL_OFS, 32'h0000_0041);
      wr(toc_pkg::CTRL_OFS, 32'h0000_0045);
      @(posedge sys_clk);
      check({31'h0, tout}, 32'h0000_0000);
      wait_irq(c);
      check({31'h0, tout}, 32'h0000_0001);
      repeat (2) @(posedge sys_clk);
      check({31'h0, tout}, 32'h0000_0001);
      rd(toc_pkg::CTRL_OFS, 32'h0000_0044);
   endtask : t_lasting
   task t_wrap;
      int c;
      wr(toc_pkg::CTRL_OFS, 32'h0000_0000);
      wr(toc_pkg::COUNT_OFS, 32'h0000_FFFE);
      wr(toc_pkg::RELOAD_OFS, 32'h0000_0000);
      wr(32'h0000_0010, 32'h0000_0005);
      rd(32'h0000_0010, 32'h0000_0000);
      rd(toc_pkg::RELOAD_OFS, 32'h0000_0000);
      rd(toc_pkg::COUNT_OFS, 32'h0000_FFFE);
      wr(toc_pkg::CTRL_OFS, 32'h0000_0001);
      wait_irq(c);
      check({31'h0, c < 12}, 32'h0000_0001);
      rd(toc_pkg::COUNT_OFS, 32'h0000_0001);
   endtask : t_wrap
   task t_counter;
      wr(toc_pkg::CTRL_OFS, 32'h0000_0046);
      // the toggle state takes the new polarity one clock after the write lands
      @(posedge sys_clk);
      rd(toc_pkg::STATUS_OFS, 32'h0000_0001);
      check({31'h0, tout}, 32'h0000_0001);
      wr(toc_pkg::COUNT_OFS, 32'h0000_0001);
      wr(toc_pkg::RELOAD_OFS, 32'h0000_0003);
      wr(toc_pkg::CTRL_OFS, 32'h0000_0047);
      edges(8'h03, i);
      check(32'(i), 32'h0000_0000);
      rd(toc_pkg::COUNT_OFS, 32'h0000_0002);
      edges(8'h03, i);
      check(32'(i), 32'h0000_0001);
      check({31'h0, tout}, 32'h0000_0000);
      rd(toc_pkg::COUNT_OFS, 32'h0000_0001);
      rd(toc_pkg::CTRL_OFS, 32'h0000_0047);
      edges(8'h06, i);
      check(32'(i), 32'h0000_0001);
      check({31'h0, tout}, 32'h0000_0001);
   endtask : t_counter
   always @(posedge sys_clk) begin
      if (rst === 1'b0) check({31'h0, irq & irq_prev}, 32'h0000_0000);
      irq_prev <= (rst === 1'b0) ? irq : 1'b0;
   end
   initial begin
      rst = 1'b1;
      hsel = 1'b0;
      htrans = 2'b00;
      haddr = 32'h0000_0000;
      hwrite = 1'b0;
      hsize = toc_pkg::HSIZE_WORD;
      hwdata = 32'h0000_0000;
      src_req = 1'b0;
      src_n = 8'h00;
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      t_reset();
      t_oneshot(3'h0, c0);
      t_oneshot(3'h3, c3);
      check(32'(c3 - c0), 32'h0000_001C);
      t_lasting();
      t_wrap();
      t_counter();
      final_report();
   end
endmodule : toc_timer_tb
`default_nettype wire

/* verif/toc_tin_src.sv */
`timescale 1ns/1ns
`default_nettype none
module toc_tin_src #(
   parameter int HALF = 4 // clocks per level; 4 gives one transition every 4 clocks, a quarter of the clock rate
) (
   input wire logic clk, // system clock
   input wire logic rst, // sync reset, high
   input wire logic req, // load a burst of transitions
   input wire logic [7:0] n_edges, // transitions in the burst
   output logic pin_ff, // drives the timer input
   output logic busy // burst in flight
);
   logic [7:0] left_ff;
   logic [7:0] ph_ff;
   assign busy = left_ff != 8'h00;
   always_ff @(posedge clk) begin
      if (rst) begin
         left_ff <= 8'h00;
         ph_ff <= 8'h00;
         pin_ff <= 1'b0;
      end else if (req && !busy) begin
         left_ff <= n_edges;
      end else if (busy) begin
         ph_ff <= (ph_ff == 8'(HALF - 1)) ? 8'h00 : ph_ff + 8'h01;
         if (ph_ff == 8'(HALF - 1)) begin
            pin_ff <= ~pin_ff;
            left_ff <= left_ff - 8'h01;
         end
      end
   end
endmodule : toc_tin_src
`default_nettype wire
